// file: hw/arf_pkg.sv
// Shared constants and types for the converter result and alert flag bank.
// Assumes a single 100 MHz clock and a byte-level register access port.
package arf_pkg;
  // ****************************************************************
  // Register pointers and reset values
  // ****************************************************************
  localparam logic [2:0] PTR_RESULT = 3'h0;
  localparam logic [2:0] PTR_STATUS = 3'h1;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic [15:0] RD_RESET = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ALERT_BIT = 15;
  localparam int CODE_MSB = 11;
  localparam int CODE_LSB = 4;
  localparam int OVER_BIT = 1;
  localparam int UNDER_BIT = 0;

  // ****************************************************************
  // Timing: internal conversion clock and phase lengths
  // ****************************************************************
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 50;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_TICKS = 8;
  localparam int CONV_TICKS = 12;
  localparam logic [2:0] TICK_LAST = 3'(TICK_CYC - 1);
  localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_TICKS - 1);
  localparam logic [3:0] CONV_LAST = 4'(CONV_TICKS - 1);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ARF_IDLE, ARF_WAIT_ACK, ARF_SAMPLE, ARF_CONVERT} arf_phase_e;

  typedef struct packed {
    logic hold;
    logic flag_en;
    logic auto_mode;
  } arf_cfg_s;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] margin_value;
  } arf_lim_s;

  typedef struct packed {
    logic [1:0] flags;
  } arf_flag_st_s;

  typedef struct packed {
    arf_phase_e phase;
    logic [2:0] div;
    logic [3:0] ticks;
    logic [7:0] ptr;
    logic [7:0] sample;
    logic [7:0] result;
    logic [15:0] rd_data;
  } arf_top_st_s;
endpackage

// file: hw/arf_flags.sv
// Over-range and under-range alert flags with hysteresis self-clear.
// Assumes done is a one-cycle pulse with code valid in that cycle.
module arf_flags
  import arf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic done,
  input wire logic [7:0] code,
  input wire arf_pkg::arf_lim_s lim,
  input wire logic hold,
  input wire logic [1:0] clr,
  output logic [1:0] flags
);
  import arf_pkg::*;

  arf_flag_st_s st;
  arf_flag_st_s next_st;
  logic over_set;
  logic under_set;
  logic over_self;
  logic under_self;

  // ****************************************************************
  // Flag update
  // ****************************************************************
  // Nine-bit sums keep limit plus or minus margin from wrapping
  always_comb begin
    over_set = done && (code > lim.high);
    under_set = done && (code < lim.low);
    over_self = done && !hold && // RULE8 RULE10
      (({1'b0, code} + {1'b0, lim.margin_value}) < {1'b0, lim.high});
    under_self = done && !hold && // RULE9 RULE10
      ({1'b0, code} > ({1'b0, lim.low} + {1'b0, lim.margin_value}));
    next_st = st;
    // Set wins over a clear arriving in the same cycle
    next_st.flags[OVER_BIT] = over_set ||
      (st.flags[OVER_BIT] && !clr[OVER_BIT] && !over_self); // RULE5 RULE7 RULE8 RULE12
    next_st.flags[UNDER_BIT] = under_set ||
      (st.flags[UNDER_BIT] && !clr[UNDER_BIT] && !under_self); // RULE6 RULE7 RULE9 RULE12
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.flags <= FLAGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.flags;

  // ****************************************************************
  // Checks
  // ****************************************************************
  over_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    done && code > lim.high |=> flags[OVER_BIT]) else $error("over flag not set");
  under_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    done && code < lim.low |=> flags[UNDER_BIT]) else $error("under flag not set");
  w1c_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    clr[OVER_BIT] && !over_set |=> !flags[OVER_BIT]) else $error("over flag not cleared");
  over_self_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    flags[OVER_BIT] && done && !hold && {1'b0, code} + {1'b0, lim.margin_value} < {1'b0, lim.high}
    |=> !flags[OVER_BIT]) else $error("over flag did not self-clear");
  under_self_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    flags[UNDER_BIT] && done && !hold &&
    {1'b0, code} > {1'b0, lim.low} + {1'b0, lim.margin_value}
    |=> !flags[UNDER_BIT]) else $error("under flag did not self-clear");
  hold_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    hold && flags[UNDER_BIT] && !clr[UNDER_BIT] |=> flags[UNDER_BIT])
    else $error("held flag lost");
  zero_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
    !done && clr == 2'h0 |=> flags == $past(flags)) else $error("flag changed without cause");
  flag_set_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(flags[OVER_BIT]));
  flag_clr_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(flags[UNDER_BIT]));
endmodule

// file: hw/arf_top.sv
// Converter result register and alert status register with pointer access.
// Assumes byte strobes come from an outside serial front end, one clock wide.
//
// Behaviour
// RULE1: The result register holds the latest finished conversion and is replaced when one ends.
// RULE2: In normal mode each read of the result register starts a new conversion; the code ignores reads outside ARF_IDLE.
// RULE3: The 8-bit code reads in bits 11:4 with its MSB at bit 11, bits 14:12 and 3:0 read zero.
// RULE4: Bit 15 of the result reads one only when mirroring is on and a flag is set.
// RULE5: The over-range flag, status bit 1, sets when a result exceeds the upper limit.
// RULE6: The under-range flag, status bit 0, sets when a result is below the lower limit.
// RULE7: Writing a one to a flag position clears that flag.
// RULE8: Without hold, the over flag clears once a result falls below upper limit minus margin.
// RULE9: Without hold, the under flag clears once a result rises above lower limit plus margin.
// RULE10: With hold set, neither flag self-clears; only a written one clears it.
// RULE11: Status bits 7:2 read zero and software writes zeros there.
// RULE12: Flags are active high, a one marks a violated limit.
// RULE13: The first byte of each write loads the pointer, whose three low bits pick the register.
// RULE14: The hold setting is configuration bit 4 and, when one, allows only write-one clearing.
// RULE15: A conversion samples for eight internal clock ticks from the acknowledge fall.
// RULE16: Writing zero to a flag leaves it alone and writes to the result register are ignored.
module arf_top
  import arf_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic BYTE_VALID,
  input wire logic BYTE_FIRST,
  input wire logic [7:0] BYTE_DATA,
  input wire logic RD_STROBE,
  input wire logic ACK_FALL,
  input wire logic AUTO_START,
  input wire arf_pkg::arf_cfg_s CFG,
  input wire arf_pkg::arf_lim_s LIMITS,
  input wire logic [7:0] ANALOG_CODE,
  output logic [15:0] RD_DATA,
  output logic [1:0] FLAGS,
  output logic BUSY
);
  import arf_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_q;
  logic rst_n;

  // Two-stage release so the whole bank leaves reset on one edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ****************************************************************
  // Access decode and conversion sequencing
  // ****************************************************************
  arf_top_st_s st;
  arf_top_st_s next_st;
  logic tick;
  logic done;
  logic start;
  logic [1:0] clr;
  logic [1:0] flags;
  logic [2:0] sel;

  assign sel = st.ptr[2:0]; // RULE13

  // Register select decode, shared by the read path, the clear path and the start
  function automatic logic sel_result(input logic [2:0] p);
    return (p == PTR_RESULT);
  endfunction

  function automatic logic sel_status(input logic [2:0] p);
    return (p == PTR_STATUS);
  endfunction

  always_comb begin
    next_st = st;
    tick = (st.div == TICK_LAST);
    done = (st.phase == ARF_CONVERT) && tick && (st.ticks == CONV_LAST);
    // A read only starts a conversion in normal mode; auto mode uses its timer
    start = CFG.auto_mode ? AUTO_START : (RD_STROBE && sel_result(sel)); // RULE2
    clr = 2'h0;
    // Internal conversion clock as a one-cycle enable
    next_st.div = tick ? 3'h0 : st.div + 3'h1;
    // Pointer load on first byte, flag clear on later bytes to status
    if (BYTE_VALID) begin
      if (BYTE_FIRST) begin
        next_st.ptr = BYTE_DATA; // RULE13
      end else if (sel_status(sel)) begin
        clr = BYTE_DATA[1:0]; // RULE7 RULE11 RULE16
      end
    end
    // Read data is captured at the strobe so it stays stable for shifting out
    if (RD_STROBE) begin
      next_st.rd_data = RD_RESET;
      if (sel_result(sel)) begin
        next_st.rd_data[ALERT_BIT] = CFG.flag_en && (|flags); // RULE4
        next_st.rd_data[CODE_MSB:CODE_LSB] = st.result; // RULE3
      end else if (sel_status(sel)) begin
        next_st.rd_data[1:0] = flags; // RULE11 RULE12
      end
    end
    unique case (st.phase)
      ARF_IDLE: begin
        if (start) begin
          next_st.phase = ARF_WAIT_ACK;
        end
      end
      ARF_WAIT_ACK: begin
        // Sampling begins at the acknowledge fall, not at the strobe
        if (ACK_FALL) begin
          next_st.phase = ARF_SAMPLE;
          next_st.ticks = 4'h0;
          next_st.div = 3'h0;
        end
      end
      ARF_SAMPLE: begin
        if (tick) begin
          if (st.ticks == SAMPLE_LAST) begin
            next_st.phase = ARF_CONVERT; // RULE15
            next_st.sample = ANALOG_CODE;
            next_st.ticks = 4'h0;
          end else begin
            next_st.ticks = st.ticks + 4'h1;
          end
        end
      end
      ARF_CONVERT: begin
        if (done) begin
          next_st.phase = ARF_IDLE;
          next_st.result = st.sample; // RULE1
        end else if (tick) begin
          next_st.ticks = st.ticks + 4'h1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st.phase <= ARF_IDLE;
      st.div <= 3'h0;
      st.ticks <= 4'h0;
      st.ptr <= PTR_RESET;
      st.sample <= RESULT_RESET;
      st.result <= RESULT_RESET;
      st.rd_data <= RD_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Alert flags
  // ****************************************************************
  arf_flags u_flags (
    .clk(CLK),
    .rst_n(rst_n),
    .done(done),
    .code(st.sample),
    .lim(LIMITS),
    .hold(CFG.hold), // RULE14 RULE10
    .clr(clr),
    .flags(flags)
  );

  assign RD_DATA = st.rd_data;
  assign FLAGS = flags;
  assign BUSY = (st.phase != ARF_IDLE);

  // ****************************************************************
  // Checks
  // ****************************************************************
  result_update_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE1
    done |=> st.result == $past(st.sample)) else $error("result not updated");
  result_keep_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE16
    !done |=> st.result == $past(st.result)) else $error("result changed without conversion");
  read_start_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE2
    st.phase == ARF_IDLE && !CFG.auto_mode && RD_STROBE && sel == PTR_RESULT
    |=> st.phase == ARF_WAIT_ACK) else $error("read did not start conversion");
  result_format_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE3
    RD_STROBE && sel == PTR_RESULT
    |=> RD_DATA[14:12] == 3'h0 && RD_DATA[3:0] == 4'h0 && RD_DATA[11:4] == $past(st.result))
    else $error("result layout wrong");
  alert_mirror_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE4
    RD_STROBE && sel == PTR_RESULT |=> RD_DATA[15] == ($past(CFG.flag_en) && (|$past(flags))))
    else $error("alert mirror wrong");
  status_read_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE11
    RD_STROBE && sel == PTR_STATUS |=> RD_DATA[15:2] == 14'h0000 && RD_DATA[1:0] == $past(flags))
    else $error("status read wrong");
  pointer_load_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE13
    BYTE_VALID && BYTE_FIRST |=> sel == $past(BYTE_DATA[2:0])) else $error("pointer not loaded");
  sample_len_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE15
    st.phase == ARF_SAMPLE && !(tick && st.ticks == SAMPLE_LAST) |=> st.phase == ARF_SAMPLE)
    else $error("sampling ended early");
  sample_begin_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE15
    st.phase == ARF_WAIT_ACK && ACK_FALL |=> st.phase == ARF_SAMPLE && st.ticks == 4'h0)
    else $error("sampling did not start at acknowledge");
  // Ack edge to done is sampling plus conversion, 40 plus 60 clocks
  conv_len_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE15
    st.phase == ARF_WAIT_ACK && ACK_FALL |-> ##100 done) else $error("conversion length wrong");
  capture_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE15
    st.phase == ARF_SAMPLE && tick && st.ticks == SAMPLE_LAST
    |=> st.phase == ARF_CONVERT && st.sample == $past(ANALOG_CODE))
    else $error("input not captured at end of sampling");
  // Auto mode ignores reads, normal mode ignores the timer pulse
  auto_read_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE2
    st.phase == ARF_IDLE && CFG.auto_mode && !AUTO_START |=> st.phase == ARF_IDLE)
    else $error("read started a conversion in auto mode");
  normal_idle_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE2
    st.phase == ARF_IDLE && !CFG.auto_mode && !(RD_STROBE && sel == PTR_RESULT)
    |=> st.phase == ARF_IDLE) else $error("conversion started without a result read");
  read_hold_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE3
    !RD_STROBE |=> $stable(RD_DATA)) else $error("read word changed between reads");
  // Clears reach the flags only through data bytes to the status register
  top_clear_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE7
    BYTE_VALID && !BYTE_FIRST && sel == PTR_STATUS && BYTE_DATA[OVER_BIT]
    && !(done && st.sample > LIMITS.high) |=> !FLAGS[OVER_BIT])
    else $error("write of one did not clear over flag");
  other_write_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE16
    BYTE_VALID && !BYTE_FIRST && sel != PTR_STATUS && !done |=> FLAGS == $past(FLAGS))
    else $error("write outside status changed flags");
  conv_done_c: cover property (@(posedge CLK) disable iff (!rst_n) done);
  auto_start_c: cover property (@(posedge CLK) disable iff (!rst_n)
    CFG.auto_mode && AUTO_START && st.phase == ARF_IDLE);
  mirror_c: cover property (@(posedge CLK) disable iff (!rst_n)
    RD_STROBE && sel == PTR_RESULT && CFG.flag_en && (|flags));
endmodule

// file: sim/arf_ctrl_model.sv
// Register controller model: pointer and data bytes, reads, acknowledge falls.
// Assumes the block samples every strobe on the rising edge of clk.
module arf_ctrl_model (
  input wire logic clk,
  output logic byte_valid,
  output logic byte_first,
  output logic [7:0] byte_data,
  output logic rd_strobe,
  output logic ack_fall
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels from time zero
  initial begin
    byte_valid = 1'b0;
    byte_first = 1'b0;
    byte_data = 8'h5A;
    rd_strobe = 1'b0;
    ack_fall = 1'b0;
  end

  // One byte held for a whole cycle; a released bus shows the inverse value
  task automatic wr(input logic first, input logic [7:0] d);
    @(posedge clk) #1;
    byte_valid = 1'b1;
    byte_first = first;
    byte_data = d;
    @(posedge clk) #1;
    byte_valid = 1'b0;
    byte_data = ~d;
  endtask

  // Read access of the register that the pointer selects
  task automatic rd();
    @(posedge clk) #1;
    rd_strobe = 1'b1;
    @(posedge clk) #1;
    rd_strobe = 1'b0;
  endtask

  // Acknowledge fall that lets a waiting conversion start sampling
  task automatic ack();
    @(posedge clk) #1;
    ack_fall = 1'b1;
    @(posedge clk) #1;
    ack_fall = 1'b0;
  endtask
endmodule

// file: sim/adc_result_and_alert_flags_test.sv
// Self-checking bench for the result and alert flag bank.
// Assumes arf_pkg and arf_top are compiled first; one 100 MHz clock.
module adc_result_and_alert_flags_test;
  timeunit 1ns;
  timeprecision 100ps;
  import arf_pkg::*;

  logic clk, rst_n, auto_start, bv, bf, rs, af, busy;
  logic [7:0] bd, code;
  arf_cfg_s cfg;
  arf_lim_s lim;
  logic [15:0] rd_data, w;
  logic [1:0] flags;
  int n_errors = 0;
  int comparisons = 0;

  arf_top u_arf_top (.CLK(clk), .RST_N(rst_n), .BYTE_VALID(bv), .BYTE_FIRST(bf),
    .BYTE_DATA(bd), .RD_STROBE(rs), .ACK_FALL(af), .AUTO_START(auto_start), .CFG(cfg),
    .LIMITS(lim), .ANALOG_CODE(code), .RD_DATA(rd_data), .FLAGS(flags), .BUSY(busy));
  arf_ctrl_model u_arf_ctrl_model (.clk(clk), .byte_valid(bv), .byte_first(bf),
    .byte_data(bd), .rd_strobe(rs), .ack_fall(af));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Full conversion; returns the word read before it. Code changes after capture.
  task automatic conv(input logic [7:0] c, output logic [15:0] prev);
    int i;
    code = c;
    u_arf_ctrl_model.wr(1'b1, 8'h00);
    u_arf_ctrl_model.rd();
    prev = rd_data;
    chk("busy after read", {15'h0, busy}, 16'h1);
    u_arf_ctrl_model.ack();
    repeat (45) @(posedge clk);
    #1 code = ~c;
    repeat (48) @(posedge clk);
    #1 chk("busy in convert", {15'h0, busy}, 16'h1);
    // Done lands 100 clocks after the ack edge: 8 plus 12 ticks of 5 clocks
    repeat (6) @(posedge clk);
    #1 chk("busy before done", {15'h0, busy}, 16'h1);
    @(posedge clk) #1;
    chk("busy end", {15'h0, busy}, 16'h0);
    // Drain a late conversion so later scenarios start idle
    i = 0;
    while (busy !== 1'b0 && i < 50) begin
      @(posedge clk);
      i++;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic clr(input logic [7:0] d);
    u_arf_ctrl_model.wr(1'b1, 8'h01);
    u_arf_ctrl_model.wr(1'b0, d);
    @(posedge clk) #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_over();
    cfg = '{hold: 1'b0, flag_en: 1'b1, auto_mode: 1'b0};
    lim = '{high: 8'hF0, low: 8'h10, margin_value: 8'h08};
    conv(8'hF5, w);
    chk("over set", {14'h0, flags}, 16'h0002);
    conv(8'hE9, w);
    chk("over kept", {14'h0, flags}, 16'h0002);
    chk("result word", w, 16'h8F50);
    u_arf_ctrl_model.wr(1'b1, 8'h01);
    u_arf_ctrl_model.rd();
    chk("status word", rd_data, 16'h0002);
    clr(8'h01);
    chk("zero write", {14'h0, flags}, 16'h0002);
    conv(8'hE7, w);
    chk("over self clear", {14'h0, flags}, 16'h0000);
    chk("result E9", w, 16'h8E90);
  endtask

  task automatic t_under();
    conv(8'h05, w);
    chk("under set", {14'h0, flags}, 16'h0001);
    conv(8'h18, w);
    chk("under kept", {14'h0, flags}, 16'h0001);
    conv(8'h19, w);
    chk("under self clear", {14'h0, flags}, 16'h0000);
    chk("result 18", w, 16'h8180);
  endtask

  task automatic t_hold();
    cfg = '{hold: 1'b1, flag_en: 1'b1, auto_mode: 1'b0};
    conv(8'hF5, w);
    conv(8'h80, w);
    chk("hold over", {14'h0, flags}, 16'h0002);
    clr(8'h02);
    chk("clear over", {14'h0, flags}, 16'h0000);
    cfg.flag_en = 1'b0;
    conv(8'h05, w);
    u_arf_ctrl_model.wr(1'b1, 8'h00);
    u_arf_ctrl_model.wr(1'b0, 8'hFF);
    conv(8'h80, w);
    chk("no mirror", w, 16'h0050);
    chk("hold under", {14'h0, flags}, 16'h0001);
    clr(8'h01);
    chk("clear under", {14'h0, flags}, 16'h0000);
  endtask

  task automatic t_auto();
    cfg = '{hold: 1'b0, flag_en: 1'b1, auto_mode: 1'b1};
    code = 8'h3C;
    u_arf_ctrl_model.wr(1'b1, 8'h00);
    u_arf_ctrl_model.rd();
    chk("auto read word", rd_data, 16'h0800);
    chk("auto read", {15'h0, busy}, 16'h0);
    @(posedge clk) #1 auto_start = 1'b1;
    @(posedge clk) #1 auto_start = 1'b0;
    chk("auto start", {15'h0, busy}, 16'h1);
    u_arf_ctrl_model.ack();
    repeat (110) @(posedge clk);
    #1 chk("auto end", {15'h0, busy}, 16'h0);
    u_arf_ctrl_model.rd();
    chk("auto result", rd_data, 16'h03C0);
    chk("auto no restart", {15'h0, busy}, 16'h0);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    auto_start = 1'b0;
    code = 8'h00;
    cfg = '0;
    lim = '0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("reset word", rd_data, 16'h0000);
    chk("reset flags", {13'h0, flags, busy}, 16'h0000);
    t_over();
    t_under();
    t_hold();
    t_auto();
    results();
  end

  // About 11 conversions of some 110 cycles each; generous margin
  initial begin
    #200us;
    n_errors++;
    results();
  end
endmodule
